// *** pkg/eps_regs.vh ***
// constants of the display sequencer controller: commands, offsets, timing
`ifndef EPS_REGS_VH
`define EPS_REGS_VH
// device command bytes
`define EPS_CMD_PANEL 8'h01
`define EPS_CMD_GATEV 8'h03
`define EPS_CMD_SRCV 8'h04
`define EPS_CMD_ENTRY 8'h11
`define EPS_CMD_UPDATE 8'h20
`define EPS_CMD_UPCTL 8'h22
`define EPS_CMD_WRRAM 8'h24
`define EPS_CMD_VSENSE 8'h28
`define EPS_CMD_VPROG 8'h2A
`define EPS_CMD_STATUS 8'h2D
`define EPS_CMD_WFPROG 8'h30
`define EPS_CMD_LUT 8'h32
`define EPS_CMD_SELPROG 8'h36
`define EPS_CMD_SELWR 8'h37
`define EPS_CMD_DUMMY 8'h3A
`define EPS_CMD_GLW 8'h3B
`define EPS_CMD_BORDER 8'h3C
`define EPS_CMD_XWIN 8'h44
`define EPS_CMD_YWIN 8'h45
`define EPS_CMD_XADR 8'h4E
`define EPS_CMD_YADR 8'h4F
`define EPS_CMD_FEEDBK 8'hF0
// data bytes
`define EPS_DAT_FEEDBK 8'h1F
`define EPS_DAT_CLKON 8'h80
`define EPS_DAT_HVON 8'h40
`define EPS_DAT_HVOFF 8'h02
`define EPS_DAT_CLKOFF 8'h01
`define EPS_DAT_ZERO 8'h00
// slot state codes and positions in the selection byte
`define EPS_SLOT_FRESH 2'h0
`define EPS_SLOT_DEF 2'h1
`define EPS_SLOT_USED 2'h3
`define EPS_SEL_COMMON_ELECTRODE_VOLTAGE_HI 7
`define EPS_SEL_COMMON_ELECTRODE_VOLTAGE_LO 6
`define EPS_SEL_WF_HI 5
`define EPS_SEL_WF_LO 4
// avalon register offsets (byte addresses)
`define EPS_REG_CTRL 4'h0
`define EPS_REG_STAT 4'h4
`define EPS_REG_CMD 4'h8
`define EPS_REG_RDAT 4'hC
// control field: bit0 go, bit1 data (1) or command (0), bit2 read
`define EPS_CTRL_GO 0
`define EPS_CTRL_DC 1
`define EPS_CTRL_RD 2
// status field positions
`define EPS_STAT_BUSYLINE 0
`define EPS_STAT_XFER 1
`define EPS_STAT_SLOTSFULL 2
// serial clock half period in clk cycles (20 MHz / 8 = 2.5 MHz)
`define EPS_SCK_HALF 4'h4
// hardware reset pulse: 10 us at 50 ns
`define EPS_RESET_NS 10000
`define EPS_CLK_NS 50
`endif

// *** src/eps_spi_shift.v ***
// one byte serial shifter towards the display driver, write or read
`timescale 1ns/1ps
module eps_spi_shift (
   input wire clk_in,
   input wire rstn_in,
   input wire start_in,
   input wire read_in,
   input wire [7:0] byte_in,
   input wire sda_in,
   output reg sck_out,
   output reg sda_out,
   output reg sda_oe_out,
   output reg [7:0] byte_out,
   output wire done_out,
   output wire active_out
);
`include "eps_regs.vh"
   reg [3:0] div;
   reg [3:0] bits;
   reg [7:0] shreg;
   reg run;
   reg done;
   reg sda_s1;
   reg sda_s2;
   reg rd;
   assign done_out = done;
   assign active_out = run;
   always @(posedge clk_in) begin
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
   end
   // msb first, data set up on falling edge, sampled on rising edge
   always @(posedge clk_in) begin
      if (!rstn_in) begin
         div <= 4'h0;
         bits <= 4'h0;
         shreg <= 8'h00;
         run <= 1'b0;
         done <= 1'b0;
         rd <= 1'b0;
         sck_out <= 1'b0;
         sda_out <= 1'b0;
         sda_oe_out <= 1'b0;
         byte_out <= 8'h00;
      end else begin
         done <= 1'b0;
         if (!run) begin
            if (start_in) begin
               run <= 1'b1;
               rd <= read_in;
               shreg <= byte_in;
               bits <= 4'h0;
               div <= 4'h0;
               sda_out <= byte_in[7];
               sda_oe_out <= !read_in;
            end
         end else if (div == `EPS_SCK_HALF - 4'h1) begin
            div <= 4'h0;
            if (!sck_out) begin
               sck_out <= 1'b1;
               if (rd)
                  shreg <= {shreg[6:0], sda_s2};
            end else begin
               sck_out <= 1'b0;
               if (bits == 4'h7) begin
                  run <= 1'b0;
                  done <= 1'b1;
                  sda_oe_out <= 1'b0;
                  byte_out <= shreg;
               end else begin
                  bits <= bits + 4'h1;
                  if (!rd) begin
                     shreg <= {shreg[6:0], 1'b0};
                     sda_out <= shreg[6];
                  end
               end
            end
         end else begin
            div <= div + 4'h1;
         end
      end
   end
endmodule // eps_spi_shift

// *** src/eps_host_ctrl.v ***
// host controller that drives the display driver through its serial pins
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "eps_regs.vh"
module eps_host_ctrl #(
   parameter RESET_CYCLES = (`EPS_RESET_NS + `EPS_CLK_NS - 1) / `EPS_CLK_NS
) (
   input wire clk_in,
   input wire rstn_in,
   input wire [3:0] avs_address_in,
   input wire avs_read_in,
   input wire avs_write_in,
   input wire [31:0] avs_writedata_in,
   output reg [31:0] avs_readdata_out,
   output wire avs_waitrequest_out,
   input wire busy_in,
   input wire sda_in,
   output wire sck_out,
   output wire sda_out,
   output wire sda_oe_out,
   output reg dc_out,
   output reg csn_out,
   output reg resn_out
);
   ////////////////////////////////////////////////////////////////////////
   localparam [4:0] ST_RESET = 5'h01;
   localparam [4:0] ST_IDLE = 5'h02;
   localparam [4:0] ST_WAITBUSY = 5'h04;
   localparam [4:0] ST_SHIFT = 5'h08;
   localparam [4:0] ST_DONE = 5'h10;

   reg [4:0] state;
   reg [4:0] next_state;
   reg [15:0] rst_cnt;
   reg busy_s1;
   reg busy_s2;
   reg [7:0] cmd_byte;
   reg want_dc;
   reg want_rd;
   reg pending;
   reg [7:0] rd_byte;
   reg slots_full;
   reg ack;
   reg start;
   wire shift_done;
   wire shift_active;
   wire [7:0] shift_byte;
   wire [1:0] sel_common_electrode_voltage;
   wire [1:0] sel_wf;
   wire sel_wr;

   ////////////////////////////////////////////////////////////////////////
   // busy pin comes from the device's own clock domain
   always @(posedge clk_in) begin
      busy_s1 <= busy_in;
      busy_s2 <= busy_s1;
   end

   eps_spi_shift u_shift (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .start_in(start),
      .read_in(want_rd),
      .byte_in(cmd_byte),
      .sda_in(sda_in),
      .sck_out(sck_out),
      .sda_out(sda_out),
      .sda_oe_out(sda_oe_out),
      .byte_out(shift_byte),
      .done_out(shift_done),
      .active_out(shift_active)
   );

   ////////////////////////////////////////////////////////////////////////
   // avalon slave: writes and reads answer at once, no wait states.
   // a byte write while a transfer runs is dropped; software polls status.
   assign avs_waitrequest_out = 1'b0;

   always @* begin
      case (avs_address_in)
         `EPS_REG_CTRL:
            avs_readdata_out = {29'h0, want_rd, want_dc, pending};
         `EPS_REG_STAT:
            avs_readdata_out = {29'h0, slots_full, pending | shift_active,
               busy_s2};
         `EPS_REG_CMD:
            avs_readdata_out = {24'h0, cmd_byte};
         `EPS_REG_RDAT:
            avs_readdata_out = {24'h0, rd_byte};
         default:
            avs_readdata_out = 32'h0;
      endcase
   end

   always @(posedge clk_in) begin
      if (!rstn_in) begin
         cmd_byte <= 8'h00;
         want_dc <= 1'b0;
         want_rd <= 1'b0;
         pending <= 1'b0;
      end else begin
         if (avs_write_in && avs_address_in == `EPS_REG_CMD && !pending)
            cmd_byte <= avs_writedata_in[7:0];
         if (avs_write_in && avs_address_in == `EPS_REG_CTRL && !pending
             && avs_writedata_in[`EPS_CTRL_GO]) begin
            want_dc <= avs_writedata_in[`EPS_CTRL_DC];
            want_rd <= avs_writedata_in[`EPS_CTRL_RD];
            pending <= 1'b1;
         end else if (ack) begin
            pending <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencer: reset pulse, then one byte per request, gated by busy
   always @* begin
      next_state = state;
      start = 1'b0;
      ack = 1'b0;
      case (state)
         ST_RESET:
            if (rst_cnt == 16'h0)
               next_state = ST_IDLE;
         ST_IDLE:
            if (pending)
               next_state = ST_WAITBUSY;
         ST_WAITBUSY:
            if (!busy_s2) begin
               start = 1'b1;
               next_state = ST_SHIFT;
            end
         ST_SHIFT:
            if (shift_done)
               next_state = ST_DONE;
         ST_DONE: begin
            ack = 1'b1;
            next_state = ST_IDLE;
         end
         default:
            next_state = ST_RESET;
      endcase
   end

   always @(posedge clk_in) begin
      if (!rstn_in) begin
         state <= ST_RESET;
         rst_cnt <= RESET_CYCLES[15:0];
         resn_out <= 1'b0;
         csn_out <= 1'b1;
         dc_out <= 1'b0;
      end else begin
         state <= next_state;
         if (state == ST_RESET) begin
            if (rst_cnt != 16'h0)
               rst_cnt <= rst_cnt - 16'h1;
            resn_out <= (rst_cnt == 16'h0);
         end
         if (start) begin
            csn_out <= 1'b0;
            // command or data byte, in the order firmware queues them
            dc_out <= want_dc;
         end else if (state == ST_DONE) begin
            csn_out <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // selection byte check after a status read (command 2D's data byte)
   assign sel_common_electrode_voltage = shift_byte[`EPS_SEL_COMMON_ELECTRODE_VOLTAGE_HI:`EPS_SEL_COMMON_ELECTRODE_VOLTAGE_LO];
   assign sel_wf = shift_byte[`EPS_SEL_WF_HI:`EPS_SEL_WF_LO];
   assign sel_wr = shift_done && want_rd;

   always @(posedge clk_in) begin
      if (!rstn_in) begin
         rd_byte <= 8'h00;
         slots_full <= 1'b0;
      end else if (sel_wr) begin
         rd_byte <= shift_byte;
         slots_full <= (sel_common_electrode_voltage == `EPS_SLOT_USED) ||
            (sel_wf == `EPS_SLOT_USED);
      end
   end
endmodule // eps_host_ctrl

// *** verif/eps_host_ctrl_asserts.sv ***
// port assertions of the display host controller
`timescale 1ns/1ps
module eps_host_ctrl_asserts (
   input wire clk_in,
   input wire rstn_in,
   input wire busy_in,
   input wire sck_out,
   input wire sda_out,
   input wire sda_oe_out,
   input wire dc_out,
   input wire csn_out
);
   reg [3:0] rises;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   // clock rises seen inside one chip-select frame
   always @(posedge clk_in) begin
      rises <= (!rstn_in || csn_out) ? 4'h0 : rises + {3'h0, $rose(sck_out)};
   end
   chk_reset_idle: assert property ($rose(rstn_in) |->
      csn_out && !sck_out && !sda_oe_out) else $error("not idle in reset");
   chk_busy_wait: assert property (busy_in [*4] |=> !$fell(csn_out))
      else $error("byte started while busy");
   chk_sck_half: assert property ($rose(sck_out) |-> sck_out [*4] ##1 !sck_out)
      else $error("serial clock half period");
   chk_sda_stable: assert property (sck_out && sda_oe_out |-> $stable(sda_out))
      else $error("data moved while clock high");
   chk_byte_bits: assert property ($rose(csn_out) |-> rises == 4'h8)
      else $error("frame without eight bits");
   chk_dc_hold: assert property (!csn_out && !$past(csn_out) |-> $stable(dc_out))
      else $error("dc moved within a byte");
   chk_sck_frame: assert property (csn_out |-> !sck_out)
      else $error("clock outside frame");
   chk_oe_frame: assert property (sda_oe_out |-> !csn_out)
      else $error("data driven outside frame");
endmodule // eps_host_ctrl_asserts

// *** verif/eps_dev_model.sv ***
// behavioural display driver: serial link, busy timing, otp slot byte
`timescale 1ns/1ps
module eps_dev_model #(
   parameter SEL_INIT = 8'h10,
   parameter BUSY_CYC = 40
) (
   input wire clk_in,
   input wire resn_in,
   input wire csn_in,
   input wire sck_in,
   input wire dc_in,
   input wire sda_in,
   output reg busy_out = 1'b0,
   output wire sda_out,
   output wire sda_oe_out,
   output reg rx_stb_out = 1'b0,
   output reg [8:0] rx_out = 9'h0
);
   reg [7:0] sel = SEL_INIT;
   reg [7:0] sh = 8'h0;
   reg [7:0] cmd = 8'h0;
   reg [3:0] bits = 4'h0;
   reg dcl = 1'b0;
   reg rdm = 1'b0;
   integer left = 0;
   assign sda_oe_out = rdm && !csn_in;
   assign sda_out = sh[7];
   always @(negedge csn_in) begin
      bits = 4'h0;
      if (rdm)
         sh = sel;
   end
   always @(posedge sck_in) begin
      if (!csn_in) begin
         sh = rdm ? sh : {sh[6:0], sda_in};
         dcl = dc_in;
         bits = bits + 4'h1;
      end
   end
   // next bit is presented on the fall, ahead of the host's sampling rise
   always @(negedge sck_in) begin
      if (!csn_in && rdm)
         sh = {sh[6:0], 1'b0};
   end
   always @(posedge csn_in) begin
      if (bits == 4'h8 && rdm)
         rdm = 1'b0;
      else if (bits == 4'h8) begin
         rx_out = {dcl, sh};
         rx_stb_out = !rx_stb_out;
         if (!dcl) begin
            cmd = sh;
            rdm = (sh == 8'h2D);
            if (sh == 8'h20 || sh == 8'h30)
               left = BUSY_CYC;
            if (sh == 8'h36 || sh == 8'h2A)
               left = BUSY_CYC;
            if (sh == 8'h28)
               left = 3 * BUSY_CYC;
         end else if (cmd == 8'h37)
            sel = sh;
      end
   end
   always @(posedge clk_in) begin
      if (!resn_in) begin
         sel = SEL_INIT;
         left = 0;
      end
      busy_out <= (left > 0);
      if (left > 0)
         left = left - 1;
   end
endmodule // eps_dev_model

// *** verif/tb_eps_host_ctrl.sv ***
// bench: avalon firmware drives the host controller into a driver model
`timescale 1ns/1ps
module tb_eps_host_ctrl;
   reg clk_in = 1'b0;
   reg rstn_in = 1'b0;
   reg avs_read_in = 1'b0;
   reg avs_write_in = 1'b0;
   reg [3:0] avs_address_in = 4'h0;
   reg [31:0] avs_writedata_in = 32'h0;
   reg [31:0] v;
   reg tog = 1'b0;
   wire [31:0] avs_readdata_out;
   wire avs_waitrequest_out, busy_in, sck_out, sda_out, sda_oe_out, dc_out;
   wire csn_out, resn_out, mso, msoe, stb;
   wire [8:0] rx;
   // released line shows a changing level, not the last bit
   wire sda_in = sda_oe_out ? sda_out : (msoe ? mso : tog);
   integer failures = 0;
   integer compares = 0;
   integer seed = 32'hCB300B05;
   reg [8:0] txq[$];
   reg [31:0] rdq[$];
   reg [31:0] rmq[$];
   reg [8:0] prog[$];
   eps_host_ctrl #(.RESET_CYCLES(4)) uut (.clk_in(clk_in), .rstn_in(rstn_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .busy_in(busy_in),
      .sda_in(sda_in), .sck_out(sck_out), .sda_out(sda_out),
      .sda_oe_out(sda_oe_out), .dc_out(dc_out), .csn_out(csn_out),
      .resn_out(resn_out));
   eps_dev_model dev (.clk_in(clk_in), .resn_in(resn_out), .csn_in(csn_out),
      .sck_in(sck_out), .dc_in(dc_out), .sda_in(sda_in), .busy_out(busy_in),
      .sda_out(mso), .sda_oe_out(msoe), .rx_stb_out(stb), .rx_out(rx));
   initial forever #25 clk_in = ~clk_in;
   always @(posedge clk_in) tog <= ~tog;
   task chk(input [31:0] got, input [31:0] exp);
      compares = compares + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task av(input w, input [3:0] a, input [31:0] d);
      avs_address_in <= a;
      avs_write_in <= w;
      avs_read_in <= !w;
      avs_writedata_in <= d;
      @(posedge clk_in);
      while (avs_waitrequest_out)
         @(posedge clk_in);
      v = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
      @(posedge clk_in);
   endtask
   task ex(input [3:0] a, input [31:0] m, input [31:0] e);
      rmq.push_back(m);
      rdq.push_back(e);
      av(1'b0, a, 32'h0);
   endtask
   task xb(input [8:0] b, input r);
      if (!r)
         txq.push_back(b);
      av(1'b1, 4'h8, {24'h0, b[7:0]});
      av(1'b1, 4'h0, {29'h0, r, b[8], 1'b1});
      v = 32'h2;
      while (v[1])
         av(1'b0, 4'h4, 32'h0);
   endtask
   // marker 1FF stands for a random data byte
   task seq(input integer a, input integer b);
      for (int i = a; i <= b; i++)
         xb(prog[i] == 9'h1FF ? {1'b1, 8'($random(seed))} : prog[i], 1'b0);
   endtask
   always @(posedge clk_in) begin
      if (avs_read_in && !avs_waitrequest_out && rdq.size() > 0)
         chk(avs_readdata_out & rmq.pop_front(), rdq.pop_front());
   end
   // skip the strobe's time-zero settling, which is no byte
   always @(stb) begin
      if ($time > 0)
         chk({23'h0, rx}, {23'h0, txq.pop_front()});
   end
   task tally_and_finish;
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #3000000;
      failures = failures + 1;
      tally_and_finish;
   end
   initial begin
      prog = '{9'h001, 9'h1FF, 9'h003, 9'h1FF, 9'h004, 9'h1FF, 9'h03A, 9'h1FF,
         9'h03B, 9'h1FF, 9'h03C, 9'h1FF, 9'h011, 9'h1FF, 9'h044, 9'h1FF,
         9'h045, 9'h1FF, 9'h04E, 9'h1FF, 9'h04F, 9'h1FF, 9'h024, 9'h1FF,
         9'h1FF, 9'h0F0, 9'h11F, 9'h020, 9'h022, 9'h140, 9'h020, 9'h032,
         9'h1FF, 9'h028, 9'h022, 9'h102, 9'h020, 9'h02A, 9'h022, 9'h101,
         9'h020, 9'h037, 9'h170, 9'h022, 9'h180, 9'h020, 9'h036, 9'h04E,
         9'h100, 9'h04F, 9'h100, 9'h024, 9'h1FF, 9'h030, 9'h022, 9'h101,
         9'h020};
      repeat (10) @(posedge clk_in);
      chk({31'h0, resn_out}, 32'h0);
      rstn_in <= 1'b1;
      @(posedge clk_in);
      ex(4'h4, 32'hFFFFFFFF, 32'h0);
      ex(4'h2, 32'hFFFFFFFF, 32'h0);
      seq(0, 27);
      chk({31'h0, resn_out}, 32'h1);
      repeat (6) @(posedge clk_in);
      ex(4'h4, 32'h1, 32'h1);
      seq(28, 40);
      xb(9'h02D, 1'b0);
      xb(9'h100, 1'b1);
      ex(4'hC, 32'hFF, 32'h10);
      ex(4'h4, 32'h4, 32'h0);
      seq(41, 56);
      xb(9'h02D, 1'b0);
      xb(9'h100, 1'b1);
      ex(4'hC, 32'hFF, 32'h70);
      ex(4'h4, 32'h4, 32'h4);
      tally_and_finish;
   end
endmodule // tb_eps_host_ctrl

bind eps_host_ctrl eps_host_ctrl_asserts chk_i (.*);
